// [tb/i2c_irq_enable_and_ack_control_test.sv]
// i2c_irq_enable_and_ack_control_test: self-checking bench of i2cie_ctrl.
// assumes i2cie_peer makes the scl frames and resolves the sda wire.
`timescale 1ns/1ps
module i2c_irq_enable_and_ack_control_test;
    typedef struct {logic [7:0] ier; logic [5:0] exp;} i2cie_row_t;
    logic i_clk, i_reset, i_wr, i_rd, i_rx_mode;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [4:0] ev;
    logic [4:0] irq;
    logic halt, scl, frame_active, sda_in, sda_out, sda_oe;
    int errors, checked;
    i2cie_row_t rows [8];

    i2cie_ctrl u_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_scl(scl),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_shift_load(ev[0]),
        .i_tx_data_write(ev[1]), .i_rx_data_read(ev[2]),
        .i_stop_det(ev[3]), .i_arb_lost(ev[4]), .i_rx_mode(i_rx_mode),
        .i_frame_active(frame_active), .i_sda_in(sda_in),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .o_tx_empty_irq(irq[4]), .o_tx_end_irq(irq[3]),
        .o_rx_full_irq(irq[2]), .o_nack_irq(irq[1]),
        .o_stop_detect_irq(irq[0]), .o_xfer_halt(halt)
    );
    i2cie_peer u_peer (
        .i_sda_oe(sda_oe), .i_sda_out(sda_out), .o_scl(scl),
        .o_frame_active(frame_active), .o_sda_in(sda_in)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic end_of_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        cmp(o_rdata, exp);
    endtask : rd

    task automatic pulse(input int n);
        @(posedge i_clk);
        ev[n] <= 1'b1;
        @(posedge i_clk);
        ev[n] <= 1'b0;
    endtask : pulse

    // requests and halt as one vector: txe, tx_end_flag, rxf, nack, stop, halt
    task automatic outs(input logic [5:0] exp);
        @(negedge i_clk);
        cmp({2'h0, irq, halt}, {2'h0, exp});
    endtask : outs

    // odd offset keeps scl unrelated in phase to i_clk; the wait covers
    // the three to four cycles the ninth-rise event needs to cross
    task automatic frame(input logic rx, input logic ack);
        @(posedge i_clk);
        i_rx_mode <= rx;
        @(negedge i_clk);
        #7;
        u_peer.frame(rx, ack);
        repeat (6) @(posedge i_clk);
    endtask : frame

    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        end_of_test();
    end

    initial begin
        i_reset = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_rx_mode = 1'b0;
        ev = 5'h00;
        errors = 0;
        checked = 0;
        rows = '{'{8'h00, 6'h00}, '{8'h80, 6'h20}, '{8'h40, 6'h10},
            '{8'h20, 6'h08}, '{8'h10, 6'h04}, '{8'h08, 6'h02},
            '{8'h04, 6'h01}, '{8'hFC, 6'h3F}};
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h00);
        outs(6'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'hFD);
        pulse(0);
        rd(8'h04, 8'h80);
        wr(8'h00, 8'hF8);
        frame(1'b0, 1'b1);
        rd(8'h00, 8'hFA);
        rd(8'h04, 8'hC0);
        outs(6'h30);
        wr(8'h00, 8'hFC);
        frame(1'b0, 1'b0);
        rd(8'h00, 8'hFC);
        frame(1'b0, 1'b1);
        rd(8'h00, 8'hFE);
        rd(8'h04, 8'hD0);
        outs(6'h35);
        pulse(3);
        pulse(4);
        rd(8'h04, 8'hDC);
        wr(8'h00, 8'hFD);
        frame(1'b1, 1'b0);
        cmp({7'h00, u_peer.seen_ack}, 8'h01);
        rd(8'h04, 8'hFC);
        rd(8'h00, 8'hFF);
        wr(8'h00, 8'hFC);
        frame(1'b1, 1'b0);
        cmp({7'h00, u_peer.seen_ack}, 8'h00);
        @(posedge i_clk);
        i_rx_mode <= 1'b0;
        foreach (rows[k]) begin
            wr(8'h00, rows[k].ier);
            outs(rows[k].exp);
        end
        // flags clear only after having been read as one
        rd(8'h04, 8'hFC);
        wr(8'h04, 8'hBF);
        outs(6'h2F);
        pulse(1);
        outs(6'h0F);
        pulse(2);
        outs(6'h07);
        wr(8'h04, 8'hEF);
        outs(6'h07);
        wr(8'h04, 8'hFB);
        outs(6'h03);
        wr(8'h04, 8'hF7);
        outs(6'h01);
        wr(8'h00, 8'h00);
        outs(6'h00);
        pulse(0);
        wr(8'h00, 8'h80);
        outs(6'h20);
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        outs(6'h00);
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        end_of_test();
    end
endmodule : i2c_irq_enable_and_ack_control_test

// [tb/i2cie_peer.sv]
// i2cie_peer: far-side bus device that makes scl frames and resolves sda.
// assumes a pull-up on sda and that scl idles high between frames.
`timescale 1ns/1ps
module i2cie_peer (
    input wire logic i_sda_oe,
    input wire logic i_sda_out,
    output logic o_scl,
    output logic o_frame_active,
    output logic o_sda_in
);
    logic drive_low;
    logic seen_ack;
    // wired-and with pull-up: whichever side pulls low wins
    assign o_sda_in = ~((i_sda_oe & ~i_sda_out) | drive_low);
    initial begin
        o_scl = 1'b1;
        o_frame_active = 1'b0;
        drive_low = 1'b0;
        seen_ack = 1'b1;
    end
    // nine scl clocks of 125 ns; when the unit receives, the peer sends
    // a changing pattern and frees sda in the ack slot, else it answers
    task automatic frame(input logic rx, input logic ack);
        o_frame_active = 1'b1;
        for (int i = 1; i <= 9; i++) begin
            #31.25;
            o_scl = 1'b0;
            drive_low = (i == 9) ? (~rx & ~ack) : (rx & i[0]);
            #31.25;
            seen_ack = o_sda_in;
            o_scl = 1'b1;
            #62.5;
        end
        o_frame_active = 1'b0;
        drive_low = 1'b0;
    endtask : frame
endmodule : i2cie_peer

// [verilog/i2cie_ctrl.sv]
// i2cie_ctrl: interrupt enables, status flags and acknowledge control of
// an i2c bus unit, plus the scl-side ack slot logic.
// assumes event inputs are one-cycle pulses on i_clk, and that i_sda_in
// and i_frame_active are valid at scl rising edges.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - tx empty request is flag and enable; enable low keeps it idle
// - tx end request rises at ninth scl rise when tx empty is set
// - tx end request drops when its flag or enable is cleared
// - rx full request follows rx data moving into receive register
// - rx full request drops when its flag or enable is cleared
// - nack request is raised by either no-ack or arbitration-lost flag
// - nack request drops on clearing both flags or its enable
// - stop detect enable gates the stop condition request
// - ack check select low ignores received ack, transfer continues
// - ack check select high: received ack of one halts the transfer
// - in transmit mode received ack bit captures the returned ack
// - received ack bit is read only; writes leave it unchanged
// - in receive mode tx ack value is driven on sda in ack slot
// - tx empty flag sets when tx data moves to the shift register
// - tx end flag sets at ninth scl rise while tx empty is set
// - rx full flag sets when received data enters the rx register
// - no-ack flag sets only on missing ack with ack check selected
module i2cie_ctrl (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic [i2cie_pkg::ADDR_W-1:0] i_addr,
    input wire logic [i2cie_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [i2cie_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_shift_load,
    input wire logic i_tx_data_write,
    input wire logic i_rx_data_read,
    input wire logic i_stop_det,
    input wire logic i_arb_lost,
    input wire logic i_rx_mode,
    input wire logic i_frame_active,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_tx_empty_irq,
    output logic o_tx_end_irq,
    output logic o_rx_full_irq,
    output logic o_nack_irq,
    output logic o_stop_detect_irq,
    output logic o_xfer_halt
);
    // register domain state
    logic tx_empty_irq_en_q;
    logic tx_end_irq_en_q;
    logic rx_full_irq_en_q;
    logic nack_irq_en_q;
    logic stop_detect_irq_en_q;
    logic ack_check_select_q;
    logic rx_ack_value_q;
    logic tx_ack_value_q;
    logic tx_empty_flag_q;
    logic tx_end_flag_q;
    logic rx_full_flag_q;
    logic no_ack_flag_q;
    logic stop_flag_q;
    logic arb_lost_flag_q;
    logic [5:0] seen_one_q;
    logic [i2cie_pkg::DATA_W-1:0] rdata_q;
    logic [i2cie_pkg::DATA_W-1:0] ier_view;
    logic [i2cie_pkg::DATA_W-1:0] stat_view;
    logic wr_ier;
    logic wr_stat;
    logic [5:0] clr_req;
    logic ninth_evt;
    logic rx_evt;
    // link domain state
    i2cie_pkg::i2cie_slot_t slot_q;
    logic [3:0] bit_cnt_q;
    logic ninth_tgl_q;
    logic rx_tgl_q;
    logic link_ack_q;
    logic sda_oe_q;
    logic link_rx_mode;
    logic link_tx_ack;

    i2cie_sync_if #(.W(2)) to_reg ();
    i2cie_sync_if #(.W(2)) to_link ();

    i2cie_sync #(.W(2)) u_sync_reg (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .port(to_reg)
    );

    i2cie_sync #(.W(2)) u_sync_link (
        .i_clk(i_scl),
        .i_reset(i_reset),
        .port(to_link)
    );

    assign to_reg.raw = {rx_tgl_q, ninth_tgl_q};
    assign ninth_evt = to_reg.pulse[0];
    assign rx_evt = to_reg.pulse[1];
    assign to_link.raw = {tx_ack_value_q, i_rx_mode};
    assign link_rx_mode = to_link.level[0];
    assign link_tx_ack = to_link.level[1];

    assign wr_ier = i_wr && (i_addr == i2cie_pkg::REG_IER);
    assign wr_stat = i_wr && (i_addr == i2cie_pkg::REG_STAT);

    // ---------------- register port ----------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_empty_irq_en_q <= 1'b0;
            tx_end_irq_en_q <= 1'b0;
            rx_full_irq_en_q <= 1'b0;
            nack_irq_en_q <= 1'b0;
            stop_detect_irq_en_q <= 1'b0;
            ack_check_select_q <= 1'b0;
            tx_ack_value_q <= 1'b0;
        end else if (wr_ier) begin
            tx_empty_irq_en_q <= i_wdata[i2cie_pkg::IER_TXE];
            tx_end_irq_en_q <= i_wdata[i2cie_pkg::IER_TX_END_FLAG];
            rx_full_irq_en_q <= i_wdata[i2cie_pkg::IER_RXF];
            nack_irq_en_q <= i_wdata[i2cie_pkg::IER_NACK];
            stop_detect_irq_en_q <= i_wdata[i2cie_pkg::IER_STOP];
            ack_check_select_q <= i_wdata[i2cie_pkg::IER_ACKCHK];
            tx_ack_value_q <= i_wdata[i2cie_pkg::IER_TXACK];
        end
    end

    // write data bit 1 is dropped: the received ack is hardware owned
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_ack_value_q <= 1'b0;
        end else if (ninth_evt && !i_rx_mode) begin
            rx_ack_value_q <= link_ack_q;
        end
    end

    always_comb begin
        ier_view = i2cie_pkg::IER_RESET;
        ier_view[i2cie_pkg::IER_TXE] = tx_empty_irq_en_q;
        ier_view[i2cie_pkg::IER_TX_END_FLAG] = tx_end_irq_en_q;
        ier_view[i2cie_pkg::IER_RXF] = rx_full_irq_en_q;
        ier_view[i2cie_pkg::IER_NACK] = nack_irq_en_q;
        ier_view[i2cie_pkg::IER_STOP] = stop_detect_irq_en_q;
        ier_view[i2cie_pkg::IER_ACKCHK] = ack_check_select_q;
        ier_view[i2cie_pkg::IER_RXACK] = rx_ack_value_q;
        ier_view[i2cie_pkg::IER_TXACK] = tx_ack_value_q;
        stat_view = i2cie_pkg::STAT_RESET;
        stat_view[i2cie_pkg::ST_TXE] = tx_empty_flag_q;
        stat_view[i2cie_pkg::ST_TX_END_FLAG] = tx_end_flag_q;
        stat_view[i2cie_pkg::ST_RXF] = rx_full_flag_q;
        stat_view[i2cie_pkg::ST_NOACK] = no_ack_flag_q;
        stat_view[i2cie_pkg::ST_STOP] = stop_flag_q;
        stat_view[i2cie_pkg::ST_ARB] = arb_lost_flag_q;
    end

    // unmapped reads return zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            case (i_addr)
                i2cie_pkg::REG_IER: rdata_q <= ier_view;
                i2cie_pkg::REG_STAT: rdata_q <= stat_view;
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;

    // ---------------- status flags ----------------
    // a flag clears by writing 0 only after it was read as 1; the
    // read-as-one memory is per flag, ordered as stat bits 7 down to 2
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            seen_one_q <= '0;
        end else if (i_rd && (i_addr == i2cie_pkg::REG_STAT)) begin
            seen_one_q <= seen_one_q | stat_view[7:2];
        end else if (wr_stat) begin
            seen_one_q <= seen_one_q & i_wdata[7:2];
        end
    end

    assign clr_req = wr_stat ? (seen_one_q & ~i_wdata[7:2]) : 6'h00;

    // set beats every clear in the same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_empty_flag_q <= 1'b0;
        end else if (i_shift_load) begin
            tx_empty_flag_q <= 1'b1;
        end else if (clr_req[5] || i_tx_data_write) begin
            tx_empty_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_end_flag_q <= 1'b0;
        end else if (ninth_evt && tx_empty_flag_q) begin
            tx_end_flag_q <= 1'b1;
        end else if (clr_req[4] || i_tx_data_write) begin
            tx_end_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_full_flag_q <= 1'b0;
        end else if (rx_evt) begin
            rx_full_flag_q <= 1'b1;
        end else if (clr_req[3] || i_rx_data_read) begin
            rx_full_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            no_ack_flag_q <= 1'b0;
        end else if (ninth_evt && !i_rx_mode && link_ack_q
                     && ack_check_select_q) begin
            no_ack_flag_q <= 1'b1;
        end else if (clr_req[2]) begin
            no_ack_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            stop_flag_q <= 1'b0;
        end else if (i_stop_det) begin
            stop_flag_q <= 1'b1;
        end else if (clr_req[1]) begin
            stop_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            arb_lost_flag_q <= 1'b0;
        end else if (i_arb_lost) begin
            arb_lost_flag_q <= 1'b1;
        end else if (clr_req[0]) begin
            arb_lost_flag_q <= 1'b0;
        end
    end

    // ---------------- requests ----------------
    // no added latency, so clearing a flag or enable drops it at once
    assign o_tx_empty_irq = tx_empty_irq_en_q & tx_empty_flag_q;
    assign o_tx_end_irq = tx_end_irq_en_q & tx_end_flag_q;
    assign o_rx_full_irq = rx_full_irq_en_q & rx_full_flag_q;
    assign o_nack_irq = nack_irq_en_q
                        & (no_ack_flag_q | arb_lost_flag_q);
    assign o_stop_detect_irq = stop_detect_irq_en_q & stop_flag_q;
    // halt only on a nack seen in transmit mode with checking on
    assign o_xfer_halt = ack_check_select_q & rx_ack_value_q
                         & ~i_rx_mode;

    // ---------------- link side, on scl ----------------
    // scl stops between frames, so nothing here waits for a late edge;
    // ack is driven from the eighth rise, one half bit early
    always_ff @(posedge i_scl or posedge i_reset) begin
        if (i_reset) begin
            slot_q <= i2cie_pkg::I2CIE_SLOT_IDLE;
            bit_cnt_q <= i2cie_pkg::BIT_CNT_RESET;
            ninth_tgl_q <= 1'b0;
            rx_tgl_q <= 1'b0;
            link_ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (!i_frame_active) begin
            slot_q <= i2cie_pkg::I2CIE_SLOT_IDLE;
            bit_cnt_q <= i2cie_pkg::BIT_CNT_RESET;
            sda_oe_q <= 1'b0;
        end else begin
            case (slot_q)
                i2cie_pkg::I2CIE_SLOT_IDLE: begin
                    slot_q <= i2cie_pkg::I2CIE_SLOT_DATA;
                    bit_cnt_q <= 4'h1;
                end
                i2cie_pkg::I2CIE_SLOT_DATA: begin
                    if (bit_cnt_q == i2cie_pkg::BITS_DATA - 4'h1) begin
                        slot_q <= i2cie_pkg::I2CIE_SLOT_ACK;
                        bit_cnt_q <= i2cie_pkg::BITS_DATA;
                        sda_oe_q <= link_rx_mode && !link_tx_ack;
                        if (link_rx_mode) begin
                            rx_tgl_q <= ~rx_tgl_q;
                        end
                    end else begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                i2cie_pkg::I2CIE_SLOT_ACK: begin
                    // ninth rise: ack is held until the next ninth rise,
                    // so the register side reads it safely on the toggle
                    slot_q <= i2cie_pkg::I2CIE_SLOT_DATA;
                    bit_cnt_q <= i2cie_pkg::BIT_CNT_RESET;
                    link_ack_q <= i_sda_in;
                    ninth_tgl_q <= ~ninth_tgl_q;
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    slot_q <= i2cie_pkg::I2CIE_SLOT_IDLE;
                    bit_cnt_q <= i2cie_pkg::BIT_CNT_RESET;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only a low is ever driven
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_q;

    // ---------------- checks ----------------
    txe_enable_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ier && !i_wdata[i2cie_pkg::IER_TXE] |=> !o_tx_empty_irq)
        else $error("tx empty request active while disabled");

    tx_end_flag_raise_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ninth_evt && tx_empty_flag_q && tx_end_irq_en_q && !wr_ier
        |=> o_tx_end_irq)
        else $error("tx end request missing after ninth rise");

    tx_end_flag_drop_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(tx_end_flag_q) || $fell(tx_end_irq_en_q)
        |-> !o_tx_end_irq)
        else $error("tx end request held after clear");

    rxf_raise_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rx_evt && rx_full_irq_en_q && !wr_ier |=> o_rx_full_irq)
        else $error("rx full request missing");

    rxf_drop_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_rx_data_read && !rx_evt |=> !o_rx_full_irq)
        else $error("rx full request held after data read");

    nack_either_a: assert property (@(posedge i_clk) disable iff (i_reset)
        nack_irq_en_q && (arb_lost_flag_q || no_ack_flag_q)
        |-> o_nack_irq)
        else $error("nack request missing");

    nack_drop_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !no_ack_flag_q && !arb_lost_flag_q |-> !o_nack_irq)
        else $error("nack request without flag");

    stop_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !stop_detect_irq_en_q |-> !o_stop_detect_irq)
        else $error("stop request while disabled");

    ack_ignore_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ier && !i_wdata[i2cie_pkg::IER_ACKCHK]
        |=> !o_xfer_halt && !$rose(no_ack_flag_q))
        else $error("halt raised with ack check off");

    ack_halt_a: assert property (@(posedge i_clk)
        disable iff (i_reset)
        ninth_evt && !i_rx_mode && link_ack_q && ack_check_select_q
        && !wr_ier ##1 !i_rx_mode |-> o_xfer_halt && no_ack_flag_q)
        else $error("nack did not halt transfer");

    rxack_ro_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_ier && !ninth_evt |=> $stable(rx_ack_value_q))
        else $error("received ack changed by write");

    txe_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_shift_load |=> tx_empty_flag_q)
        else $error("tx empty flag not set on shift load");

    ack_drive_a: assert property (@(posedge i_scl) disable iff (i_reset)
        i_frame_active && slot_q == i2cie_pkg::I2CIE_SLOT_DATA
        && bit_cnt_q == 4'h7 && link_rx_mode && !link_tx_ack
        |=> o_sda_oe ##1 !o_sda_oe)
        else $error("ack slot drive wrong");
endmodule : i2cie_ctrl

// [verilog/i2cie_pkg.sv]
// i2cie_pkg: register map, field positions, reset values and link states
// for the i2c interrupt-enable and acknowledge-control block.
// assumes an 8-bit register port and a link clocked by scl.
package i2cie_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_IER = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    // irq_enable_ack_ctrl_reg fields
    localparam int IER_TXE = 7;
    localparam int IER_TX_END_FLAG = 6;
    localparam int IER_RXF = 5;
    localparam int IER_NACK = 4;
    localparam int IER_STOP = 3;
    localparam int IER_ACKCHK = 2;
    localparam int IER_RXACK = 1;
    localparam int IER_TXACK = 0;
    // bus_status_reg fields
    localparam int ST_TXE = 7;
    localparam int ST_TX_END_FLAG = 6;
    localparam int ST_RXF = 5;
    localparam int ST_NOACK = 4;
    localparam int ST_STOP = 3;
    localparam int ST_ARB = 2;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [3:0] BITS_DATA = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    typedef enum logic [2:0] {
        I2CIE_SLOT_IDLE = 3'b001,
        I2CIE_SLOT_DATA = 3'b010,
        I2CIE_SLOT_ACK = 3'b100
    } i2cie_slot_t;
endpackage : i2cie_pkg

// [verilog/i2cie_sync.sv]
// i2cie_sync: three-flop synchroniser; a change counts once the second
// and third stages agree. assumes raw is stable for three receiving clocks.
`timescale 1ns/1ps
module i2cie_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    i2cie_sync_if.sync port
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] agree;

    if (W < 1) begin : g_chk
        $error("i2cie_sync: W must be at least 1");
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= port.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // glitch of one clock in s2 never reaches level
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            level_q <= '0;
        end else begin
            level_q <= (level_q & ~agree) | (s3_q & agree);
        end
    end

    assign port.level = level_q;
    assign port.pulse = agree & (s3_q ^ level_q);
endmodule : i2cie_sync

// [verilog/i2cie_sync_if.sv]
// i2cie_sync_if: raw bits entering a synchroniser and their settled
// levels and one-cycle change pulses in the receiving domain.
// assumes raw is driven from a single foreign clock domain.
`timescale 1ns/1ps
interface i2cie_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] pulse;
    modport src (output raw, input level, input pulse);
    modport sync (input raw, output level, output pulse);
endinterface : i2cie_sync_if
